// ### logic/rxf_frame_proc.sv
// receive frame processing: address filter, checks, status and counters
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module rxf_frame_proc
    import rxf_pkg::*;
(
    // system
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // mii receive pins
    input  wire logic        rxClk,
    input  wire logic        rxDv,
    input  wire logic        rxEr,
    input  wire logic [3:0]  rxd,
    // register port
    input  wire logic [5:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output logic [31:0]      regRdData,
    // local receive memory
    output logic             memReq,
    input  wire logic        memAck,
    output logic [31:0]      memData,
    input  wire logic        memFull,
    // event pulses
    output logic             frameDone,
    output logic             overflowEvt,
    output logic             rxErrEvt,
    output logic             counterEvt
);
    typedef enum logic [3:0] {
        S_HUNT   = 4'b0001,
        S_ADDR   = 4'b0010,
        S_DATA   = 4'b0100,
        S_IGNORE = 4'b1000
    } rxf_state_t;

    function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int k = 0; k < 8; k++) begin
            r = (r[31] ^ d[k]) ? ({r[30:0], 1'b0} ^ CRC_POLY) : {r[30:0], 1'b0};
        end
        return r;
    endfunction

    function automatic logic [7:0] cntStep(input logic [7:0] v, input logic inc,
                                           input logic clr);
        logic [7:0] b;
        b = clr ? 8'h00 : v;
        if (inc && b != CNT_MAX)
            b = b + 8'h01;
        return b;
    endfunction

    // pin synchronisers; link clock edges found by the system clock
    logic [2:0] clkSync_reg;
    logic [1:0] dvSync_reg;
    logic [1:0] erSync_reg;
    logic [3:0] rxdS1_reg;
    logic [3:0] rxdS2_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clkSync_reg <= 3'b000;
            dvSync_reg  <= 2'b00;
            erSync_reg  <= 2'b00;
            rxdS1_reg   <= 4'h0;
            rxdS2_reg   <= 4'h0;
        end else begin
            clkSync_reg <= {clkSync_reg[1:0], rxClk};
            dvSync_reg  <= {dvSync_reg[0], rxDv};
            erSync_reg  <= {erSync_reg[0], rxEr};
            rxdS1_reg   <= rxd;
            rxdS2_reg   <= rxdS1_reg;
        end
    end

    // phy drives on the falling edge, so data is settled at the rising one
    wire       linkEdge = clkSync_reg[1] && !clkSync_reg[2];
    wire       dv       = dvSync_reg[1];
    wire       er       = erSync_reg[1];
    wire [3:0] nib      = rxdS2_reg;

    // software registers
    logic [CTRL_W-1:0] ctrl_reg;
    logic [47:0]       sta_reg;
    logic [63:0]       hash_reg;
    logic [15:0]       slot_reg;
    logic [ST_W-1:0]   status_reg;
    logic [7:0]        cnt_reg [3];

    wire promisc = ctrl_reg[CTRL_PROMISC];
    wire bcastEn = ctrl_reg[CTRL_BCAST];
    wire mcastEn = ctrl_reg[CTRL_MCAST];
    wire runtsEn = ctrl_reg[CTRL_RUNTS];
    wire errEn   = ctrl_reg[CTRL_ERRORED];
    wire longChk = ctrl_reg[CTRL_LONGCHK];
    wire monitor = ctrl_reg[CTRL_MONITOR];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            sta_reg  <= 48'h000000000000;
            hash_reg <= 64'h0000000000000000;
            slot_reg <= SLOT_RESET;
        end else if (regWrStb) begin
            case (regAddr)
                OFF_CTRL:    ctrl_reg        <= regWrData[CTRL_W-1:0];
                OFF_STA_LO:  sta_reg[31:0]   <= regWrData;
                OFF_STA_HI:  sta_reg[47:32]  <= regWrData[15:0];
                OFF_HASH_LO: hash_reg[31:0]  <= regWrData;
                OFF_HASH_HI: hash_reg[63:32] <= regWrData;
                OFF_SLOT:    slot_reg        <= regWrData[15:0];
                default:     ;
            endcase
        end
    end

    // frame state
    rxf_state_t  state_reg;
    rxf_state_t  state_next;
    logic [3:0]  prevNib_reg;
    logic [3:0]  lowNib_reg;
    logic        hiPhase_reg;
    logic [11:0] byteCnt_reg;
    logic [31:0] crc_reg;
    logic        erSeen_reg;
    logic        uniOk_reg;
    logic        bcOk_reg;
    logic        group_reg;
    logic        accepted_reg;
    logic        mcastHit_reg;

    wire inFrame  = (state_reg == S_ADDR) || (state_reg == S_DATA);
    wire sfdHit   = (state_reg == S_HUNT) && linkEdge && dv
                    && ({nib, prevNib_reg} == SFD_BYTE);
    wire [7:0] newByte = {nib, lowNib_reg};
    wire byteDone = inFrame && linkEdge && dv && hiPhase_reg;
    wire frameEnd = inFrame && linkEdge && !dv;
    wire [31:0] crcNext = crcByte(crc_reg, newByte);

    // address recognition over destination bytes 1..6
    wire [11:0] dstIdx   = byteCnt_reg - 12'h001;
    wire [7:0]  staByte  = sta_reg[8*dstIdx[2:0] +: 8];
    wire        byteMatch = (newByte == staByte);
    wire        lastDst  = (state_reg == S_ADDR) && byteDone
                           && (byteCnt_reg == DST_LAST);
    wire        firstDst = (byteCnt_reg == 12'h001);
    wire        uniFin   = uniOk_reg && byteMatch;
    wire        bcFin    = bcOk_reg && (newByte == BCAST_BYTE);
    wire        grpFin   = firstDst ? newByte[0] : group_reg;
    wire [5:0]  hashIdx  = crcNext[31:26];
    wire        hashBit  = hash_reg[hashIdx];
    wire        mcHit    = grpFin && mcastEn && hashBit;
    wire        bcHit    = bcFin && (bcastEn || hashBit);
    wire        acceptNow = promisc || (!grpFin && uniFin) || mcHit || bcHit;
    wire        reject   = lastDst && !acceptNow;

    // memory full while storing ends the frame at once
    wire storing  = inFrame && !monitor && (state_reg == S_DATA || !reject);
    wire overflow = storing && memFull && !frameEnd;

    // end-of-frame checks
    wire [11:0] frameLen = byteCnt_reg - 12'h001;
    wire        isRunt   = ({1'b0, byteCnt_reg, 3'b000} <= slot_reg);
    wire        isLong   = longChk && (frameLen > LONG_LIMIT);
    wire        crcBad   = (crc_reg != CRC_RESIDUE) || erSeen_reg;
    wire        alignBad = crcBad && hiPhase_reg;
    wire        goodFrm  = accepted_reg && !(crcBad && !errEn)
                           && !(isRunt && !runtsEn);
    wire        keepFrm  = goodFrm && !monitor;
    wire        endEval  = frameEnd;

    // fifo link
    rxf_fifo_if fifoBus ();
    assign fifoBus.byteValid = byteDone && storing && !overflow;
    assign fifoBus.byteData  = newByte;
    assign fifoBus.flush     = reject || overflow || (endEval && !keepFrm && !monitor);
    assign fifoBus.finish    = endEval && keepFrm;

    rxf_stage_fifo stageFifo (
        .sys_clk (sys_clk),
        .rst     (rst),
        .fifo    (fifoBus),
        .memReq  (memReq),
        .memAck  (memAck),
        .memData (memData)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_HUNT:   if (sfdHit) state_next = S_ADDR;
            S_ADDR:   if (frameEnd) state_next = S_HUNT;
                      else if (reject || overflow) state_next = S_IGNORE;
                      else if (lastDst) state_next = S_DATA;
            S_DATA:   if (frameEnd) state_next = S_HUNT;
                      else if (overflow) state_next = S_IGNORE;
            S_IGNORE: if (linkEdge && !dv) state_next = S_HUNT;
            default:  state_next = S_HUNT;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg    <= S_HUNT;
            prevNib_reg  <= 4'h0;
            lowNib_reg   <= 4'h0;
            hiPhase_reg  <= 1'b0;
            byteCnt_reg  <= 12'h000;
            crc_reg      <= CRC_INIT;
            erSeen_reg   <= 1'b0;
            uniOk_reg    <= 1'b0;
            bcOk_reg     <= 1'b0;
            group_reg    <= 1'b0;
            accepted_reg <= 1'b0;
            mcastHit_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (linkEdge)
                prevNib_reg <= dv ? nib : 4'h0;
            if (sfdHit) begin
                byteCnt_reg  <= 12'h001;
                crc_reg      <= CRC_INIT;
                hiPhase_reg  <= 1'b0;
                erSeen_reg   <= er;
                uniOk_reg    <= 1'b1;
                bcOk_reg     <= 1'b1;
                group_reg    <= 1'b0;
                accepted_reg <= 1'b0;
                mcastHit_reg <= 1'b0;
            end else if (inFrame && linkEdge && dv) begin
                erSeen_reg  <= erSeen_reg || er;
                hiPhase_reg <= !hiPhase_reg;
                if (!hiPhase_reg)
                    lowNib_reg <= nib;
                else begin
                    crc_reg <= crcNext;
                    if (byteCnt_reg != CNT_SAT)
                        byteCnt_reg <= byteCnt_reg + 12'h001;
                    if (state_reg == S_ADDR) begin
                        uniOk_reg <= uniFin;
                        bcOk_reg  <= bcFin;
                        group_reg <= grpFin;
                    end
                    if (lastDst) begin
                        accepted_reg <= acceptNow;
                        mcastHit_reg <= grpFin && !bcFin;
                    end
                end
            end
        end
    end

    // status and event pulses
    wire crcInc  = endEval && crcBad && !isLong;
    wire alnInc  = endEval && alignBad && !isLong;
    wire missMon = endEval && monitor && goodFrm;
    wire missInc = overflow || missMon;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_reg  <= '0;
            frameDone   <= 1'b0;
            overflowEvt <= 1'b0;
            rxErrEvt    <= 1'b0;
        end else begin
            frameDone   <= endEval && keepFrm;
            overflowEvt <= overflow;
            rxErrEvt    <= endEval && crcBad && !monitor;
            if (endEval) begin
                status_reg           <= '0;
                status_reg[ST_GOOD]  <= goodFrm;
                status_reg[ST_CRC]   <= crcBad;
                status_reg[ST_ALIGN] <= alignBad;
                status_reg[ST_RUNT]  <= isRunt;
                status_reg[ST_LONG]  <= isLong;
                status_reg[ST_MCAST] <= mcastHit_reg;
                status_reg[ST_BCAST] <= accepted_reg && bcOk_reg;
            end else if (overflow) begin
                status_reg          <= '0;
                status_reg[ST_OVER] <= 1'b1;
            end
        end
    end

    // event counters: a read clears, an event in the same cycle still counts
    wire [2:0] cntInc = {missInc, alnInc, crcInc};
    logic [2:0] cntWarn;

    for (genvar i = 0; i < 3; i++) begin : g_cnt
        wire       clr  = regRdStb && (regAddr == CNT_OFFS[6*i +: 6]);
        wire [7:0] nxt  = cntStep(cnt_reg[i], cntInc[i], clr);
        assign cntWarn[i] = (nxt == CNT_WARN) && (cnt_reg[i] != CNT_WARN);
        always_ff @(posedge sys_clk) begin
            if (rst)
                cnt_reg[i] <= 8'h00;
            else
                cnt_reg[i] <= nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            counterEvt <= 1'b0;
        else
            counterEvt <= |cntWarn;
    end

    // read port: data in the cycle after the strobe, unmapped reads as zero
    wire [31:0] rdMux =
        (regAddr == OFF_CTRL)    ? {25'h0000000, ctrl_reg} :
        (regAddr == OFF_STATUS)  ? {24'h000000, status_reg} :
        (regAddr == OFF_STA_LO)  ? sta_reg[31:0] :
        (regAddr == OFF_STA_HI)  ? {16'h0000, sta_reg[47:32]} :
        (regAddr == OFF_HASH_LO) ? hash_reg[31:0] :
        (regAddr == OFF_HASH_HI) ? hash_reg[63:32] :
        (regAddr == OFF_SLOT)    ? {16'h0000, slot_reg} :
        (regAddr == OFF_CNT_CRC) ? {24'h000000, cnt_reg[0]} :
        (regAddr == OFF_CNT_ALN) ? {24'h000000, cnt_reg[1]} :
        (regAddr == OFF_CNT_MIS) ? {24'h000000, cnt_reg[2]} :
                                   32'h00000000;

    always_ff @(posedge sys_clk) begin
        if (rst)
            regRdData <= 32'h00000000;
        else if (regRdStb)
            regRdData <= rdMux;
        else
            regRdData <= 32'h00000000;
    end
endmodule

// ### logic/rxf_pkg.sv
// constants for the receive frame processor
package rxf_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [5:0] OFF_CTRL    = 6'h00;
    localparam logic [5:0] OFF_STATUS  = 6'h04;
    localparam logic [5:0] OFF_STA_LO  = 6'h08;
    localparam logic [5:0] OFF_STA_HI  = 6'h0c;
    localparam logic [5:0] OFF_HASH_LO = 6'h10;
    localparam logic [5:0] OFF_HASH_HI = 6'h14;
    localparam logic [5:0] OFF_SLOT    = 6'h18;
    localparam logic [5:0] OFF_CNT_CRC = 6'h1c;
    localparam logic [5:0] OFF_CNT_ALN = 6'h20;
    localparam logic [5:0] OFF_CNT_MIS = 6'h24;
    localparam logic [17:0] CNT_OFFS   = {OFF_CNT_MIS, OFF_CNT_ALN, OFF_CNT_CRC};
    // control register fields
    localparam int CTRL_PROMISC = 0;
    localparam int CTRL_BCAST   = 1;
    localparam int CTRL_MCAST   = 2;
    localparam int CTRL_RUNTS   = 3;
    localparam int CTRL_ERRORED = 4;
    localparam int CTRL_LONGCHK = 5;
    localparam int CTRL_MONITOR = 6;
    localparam int CTRL_W       = 7;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    // status register fields
    localparam int ST_GOOD  = 0;
    localparam int ST_CRC   = 1;
    localparam int ST_ALIGN = 2;
    localparam int ST_OVER  = 3;
    localparam int ST_RUNT  = 4;
    localparam int ST_LONG  = 5;
    localparam int ST_MCAST = 6;
    localparam int ST_BCAST = 7;
    localparam int ST_W     = 8;
    // framing and checking
    localparam logic [7:0]  SFD_BYTE      = 8'hd5;
    localparam logic [7:0]  BCAST_BYTE    = 8'hff;
    localparam logic [31:0] CRC_INIT      = 32'hffffffff;
    localparam logic [31:0] CRC_POLY      = 32'h04c11db7;
    localparam logic [31:0] CRC_RESIDUE   = 32'hc704dd7b;
    localparam logic [11:0] DST_LAST      = 12'h006;
    localparam logic [11:0] LONG_LIMIT    = 12'h5ee;
    localparam logic [11:0] CNT_SAT       = 12'hfff;
    localparam logic [15:0] SLOT_RESET    = 16'h0200;
    // event counters
    localparam logic [7:0]  CNT_MAX       = 8'hff;
    localparam logic [7:0]  CNT_WARN      = 8'hc0;
    // staging fifo
    localparam int          FIFO_DEPTH    = 8;
    localparam logic [3:0]  FIFO_FULL     = 4'h8;
    localparam logic [3:0]  BURST_LEVEL   = 4'h6;
endpackage

// ### logic/rxf_fifo_if.sv
// byte stream from frame processor into staging fifo
`timescale 1ns/1ps
interface rxf_fifo_if;
    logic       byteValid;
    logic [7:0] byteData;
    logic       flush;
    logic       finish;
    logic [3:0] level;
    modport producer (output byteValid, output byteData, output flush, output finish,
                      input level);
    modport buffer (input byteValid, input byteData, input flush, input finish,
                    output level);
endinterface

// ### logic/rxf_stage_fifo.sv
// staging fifo: packs bytes into dwords and bursts them to local memory
`timescale 1ns/1ps
module rxf_stage_fifo
    import rxf_pkg::*;
(
    // system
    input  wire logic   sys_clk,
    input  wire logic   rst,
    // byte side
    rxf_fifo_if.buffer  fifo,
    // local memory side
    output logic        memReq,
    input  wire logic   memAck,
    output logic [31:0] memData
);
    logic [31:0] store [FIFO_DEPTH];
    logic [23:0] pack_reg;
    logic [1:0]  packCnt_reg;
    logic [2:0]  wrPtr_reg;
    logic [2:0]  rdPtr_reg;
    logic [3:0]  level_reg;
    logic        tail_reg;

    wire        full     = (level_reg == FIFO_FULL);
    wire        empty    = (level_reg == 4'h0);
    wire        wordDone = fifo.byteValid && (packCnt_reg == 2'd3);
    wire        padDone  = fifo.finish && (packCnt_reg != 2'd0);
    // acknowledge is guaranteed in time, so a push into a full fifo is simply lost
    wire        push     = (wordDone || padDone) && !full;
    wire        pop      = memAck && !empty;
    wire [31:0] wordIn   = wordDone ? {fifo.byteData, pack_reg} :
                           (packCnt_reg == 2'd1) ? {24'h000000, pack_reg[7:0]} :
                           (packCnt_reg == 2'd2) ? {16'h0000, pack_reg[15:0]} :
                                                   {8'h00, pack_reg};
    wire [3:0]  levelNext = level_reg + {3'b000, push} - {3'b000, pop};

    assign fifo.level = level_reg;
    assign memData    = store[rdPtr_reg];
    // burst once six dwords wait, or drain the tail of an accepted frame
    assign memReq     = (level_reg >= BURST_LEVEL) || (tail_reg && !empty);

    always_ff @(posedge sys_clk) begin
        if (rst || fifo.flush) begin
            packCnt_reg <= 2'd0;
            pack_reg    <= 24'h000000;
            wrPtr_reg   <= 3'd0;
            rdPtr_reg   <= 3'd0;
            level_reg   <= 4'h0;
            tail_reg    <= 1'b0;
        end else begin
            if (fifo.byteValid) begin
                pack_reg[8*packCnt_reg +: 8] <= fifo.byteData;
                packCnt_reg <= packCnt_reg + 2'd1;
            end else if (fifo.finish) begin
                packCnt_reg <= 2'd0;
            end
            if (push)
                wrPtr_reg <= wrPtr_reg + 3'd1;
            if (pop)
                rdPtr_reg <= rdPtr_reg + 3'd1;
            level_reg <= levelNext;
            if (fifo.finish)
                tail_reg <= 1'b1;
            else if (fifo.byteValid || levelNext == 4'h0)
                tail_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                store[i] <= 32'h00000000;
            end
        end else if (push) begin
            store[wrPtr_reg] <= wordIn;
        end
    end
endmodule

// ### bench/rxf_frame_checker.sv
// port assertions for the receive frame processor
`timescale 1ns/1ps
module rxf_frame_checker
    import rxf_pkg::*;
(
    // system
    input wire logic        sys_clk,
    input wire logic        rst,
    // watched pins
    input wire logic        rxDv,
    input wire logic [5:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrStb,
    input wire logic        regRdStb,
    input wire logic [31:0] regRdData,
    input wire logic        memReq,
    input wire logic        memAck,
    input wire logic [31:0] memData,
    input wire logic        memFull,
    input wire logic        frameDone,
    input wire logic        overflowEvt,
    input wire logic        rxErrEvt
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // shadow of the monitor bit, seen from the write port
    logic monReg;
    always_ff @(posedge sys_clk)
        if (rst) monReg <= 1'b0;
        else if (regWrStb && regAddr == OFF_CTRL) monReg <= regWrData[CTRL_MONITOR];

    mon_err_a: assert property (rxErrEvt |-> !monReg) else $error("error event in monitor");
    mon_store_a: assert property (monReg |-> !memReq) else $error("monitor mode stores");
    head_hold_a: assert property (memReq && !memAck ##1 memReq |-> $stable(memData))
        else $error("head moved without ack");
    ovf_cause_a: assert property (overflowEvt |-> memFull || $past(memFull))
        else $error("overflow without full memory");
    ovf_once_a: assert property (overflowEvt |=> !overflowEvt) else $error("overflow twice");
    done_end_a: assert property (frameDone |-> !rxDv && !overflowEvt)
        else $error("done before frame end");
    done_drain_a: assert property (frameDone |-> ##[0:40] !memReq) else $error("tail stuck");
    err_once_a: assert property (rxErrEvt |=> !rxErrEvt) else $error("error event twice");
    cnt_range_a: assert property (regRdStb && regAddr == OFF_CNT_CRC |=> regRdData <= 32'hff)
        else $error("counter above 8 bits");
endmodule
bind rxf_frame_proc rxf_frame_checker i_chk (.sys_clk, .rst, .rxDv, .regAddr, .regWrData,
    .regWrStb, .regRdStb, .regRdData, .memReq, .memAck, .memData, .memFull, .frameDone,
    .overflowEvt, .rxErrEvt);

// ### bench/rxf_phy_model.sv
// physical layer receive side, one nibble per link clock
`timescale 1ns/1ps
module rxf_phy_model (
    // mii receive pins
    output logic       rxClk,
    output logic       rxDv,
    output logic       rxEr,
    output logic [3:0] rxd
);
    initial begin
        rxClk = 1'b0;
        rxDv = 1'b0;
        rxEr = 1'b0;
        rxd = 4'h0;
    end
    task automatic nib(input logic [3:0] n, input logic e);
        rxd = n;
        rxEr = e;
        #80 rxClk = 1'b1;
        #80 rxClk = 1'b0;
    endtask
    // clock stands still between frames; one idle edge closes the frame
    task automatic send(input logic [7:0] b[$], input logic odd, input logic er);
        rxDv = 1'b1;
        repeat (15) nib(4'h5, 1'b0);
        nib(4'hd, 1'b0);
        foreach (b[i]) begin
            nib(b[i][3:0], er && i == 10);
            nib(b[i][7:4], 1'b0);
        end
        if (odd) nib(4'h3, 1'b0);
        rxDv = 1'b0;
        nib(~rxd, 1'b0);
    endtask
endmodule

// ### bench/tb.sv
// self-checking bench for the receive frame processor
`timescale 1ns/1ps
module tb
    import rxf_pkg::*;
;
    localparam logic [47:0] STA = 48'h0a0b0c0d0e02;
    localparam logic [47:0] MC  = 48'h665544332201;
    logic        sys_clk = 0, rst = 1, regWrStb = 0, regRdStb = 0, memAck = 0, memFull = 0;
    logic [5:0]  regAddr = 0;
    logic [31:0] regWrData = 0, memQ[$], rdQ[$];
    wire logic   rxClk, rxDv, rxEr, memReq, frameDone, overflowEvt, rxErrEvt, counterEvt;
    wire logic [3:0]  rxd;
    wire logic [31:0] regRdData, memData;
    logic [7:0]  bq[$];
    logic        rdPend = 0;
    int num_errors = 0, compares = 0, seed = 91035, cyc = 0;
    int nDone = 0, nOvf = 0, nErr = 0, eDone = 0, nCnt = 0;
    rxf_frame_proc i_dut (.sys_clk, .rst, .rxClk, .rxDv, .rxEr, .rxd, .regAddr, .regWrData,
        .regWrStb, .regRdStb, .regRdData, .memReq, .memAck, .memData, .memFull, .frameDone,
        .overflowEvt, .rxErrEvt, .counterEvt);
    rxf_phy_model i_phy (.rxClk, .rxDv, .rxEr, .rxd);
    always #10 sys_clk = ~sys_clk;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task test_done;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (rdPend) chk("regRdData", rdQ.pop_front(), regRdData);
        rdPend <= regRdStb;
        // ack every other cycle so the fifo really fills
        if (memReq && memAck && memQ.size() == 0) chk("extra dword", 0, 1);
        else if (memReq && memAck) chk("memData", memQ.pop_front(), memData);
        memAck <= memReq && !memAck && !memFull;
        nDone += frameDone;
        nOvf += overflowEvt;
        nErr += rxErrEvt;
        nCnt += counterEvt;
        if (cyc == 80000) begin
            num_errors++;
            test_done();
        end
    end
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask
    task rd(input logic [5:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
    endtask
    function automatic logic [31:0] crc(input int n);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < n; i++) begin
            c ^= bq[i];
            repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        end
        return c;
    endfunction
    function automatic logic [5:0] hidx(input logic [47:0] d);
        logic [31:0] c;
        bq = {};
        for (int i = 0; i < 6; i++) bq.push_back(d[8*i +: 8]);
        c = crc(6);
        return {c[0], c[1], c[2], c[3], c[4], c[5]};
    endfunction
    // f: 0 bad fcs, 1 odd nibble, 2 link error, 3 expect stored
    task frame(input logic [47:0] dst, input int len, input logic [3:0] f);
        logic [31:0] c;
        bq = {};
        for (int i = 0; i < len - 4; i++) bq.push_back(i < 6 ? dst[8*i +: 8] : 8'($random(seed)));
        c = ~crc(len - 4) ^ {31'h0, f[0]};
        for (int i = 0; i < 4; i++) bq.push_back(c[8*i +: 8]);
        if (f[3]) for (int i = 0; i < len; i += 4) memQ.push_back({bq[i+3], bq[i+2], bq[i+1], bq[i]});
        eDone += f[3];
        i_phy.send(bq, f[1], f[2]);
        repeat (60) @(posedge sys_clk);
        chk("frameDone count", eDone, nDone);
    endtask
    initial begin
        logic [63:0] h;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(OFF_SLOT, 32'h200);
        rd(OFF_CTRL, 32'h0);
        rd(6'h3c, 32'h0);
        wr(OFF_SLOT, 32'h100);
        wr(OFF_STA_LO, STA[31:0]);
        wr(OFF_STA_HI, {16'h0, STA[47:32]});
        wr(OFF_CTRL, 32'h2);
        frame(STA, 36, 4'h8);
        rd(OFF_STATUS, 32'h1);
        frame(STA ^ 48'h800000000000, 36, 4'h0);
        frame(48'hffffffffffff, 40, 4'h8);
        rd(OFF_STATUS, 32'h81);
        h = 64'h1 << hidx(MC);
        wr(OFF_HASH_LO, h[31:0]);
        wr(OFF_HASH_HI, h[63:32]);
        wr(OFF_CTRL, 32'h6);
        frame(MC, 36, 4'h8);
        rd(OFF_STATUS, 32'h41);
        h = ~h;
        wr(OFF_HASH_LO, h[31:0]);
        wr(OFF_HASH_HI, h[63:32]);
        frame(MC, 36, 4'h0);
        wr(OFF_CTRL, 32'h1);
        frame({$random(seed), 16'h1230}, 36, 4'h8);
        wr(OFF_CTRL, 32'h2);
        frame(STA, 20, 4'h0);
        wr(OFF_CTRL, 32'ha);
        frame(STA, 20, 4'h8);
        frame(STA, 20, 4'h1);
        rd(OFF_STATUS, 32'h12);
        rd(OFF_CNT_CRC, 32'h1);
        rd(OFF_CNT_CRC, 32'h0);
        wr(OFF_CTRL, 32'h10);
        frame(STA, 36, 4'h9);
        rd(OFF_STATUS, 32'h3);
        rd(OFF_CNT_CRC, 32'h1);
        wr(OFF_CTRL, 32'h40);
        frame(STA, 36, 4'h0);
        rd(OFF_CNT_MIS, 32'h1);
        frame(STA, 36, 4'h3);
        rd(OFF_CNT_CRC, 32'h1);
        rd(OFF_CNT_ALN, 32'h1);
        frame(STA, 36, 4'h4);
        rd(OFF_CNT_CRC, 32'h1);
        wr(OFF_CTRL, 32'h60);
        frame(STA, 1520, 4'h1);
        rd(OFF_STATUS, 32'h22);
        rd(OFF_CNT_CRC, 32'h0);
        wr(OFF_CTRL, 32'h2);
        memFull <= 1'b1;
        frame(STA, 36, 4'h0);
        rd(OFF_CNT_MIS, 32'h1);
        // bare delimiter frames: each aborts on full memory, walking the counter to 192
        bq = {};
        repeat (192) i_phy.send(bq, 1'b0, 1'b0);
        memFull <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(OFF_CNT_MIS, 32'hc0);
        repeat (4) @(posedge sys_clk);
        chk("rxErrEvt count", 2, nErr);
        chk("overflowEvt count", 193, nOvf);
        chk("counterEvt count", 1, nCnt);
        chk("dwords left", 0, memQ.size());
        test_done();
    end
endmodule
